// File: rtl/pdc_pkg.sv
// Package of constants and types for the power-down mode controller
package pdc_pkg;

    // Register bus geometry
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [1:0] OFS_SYSCTL = 2'h0;
    localparam logic [1:0] OFS_STATUS = 2'h1;

    // Field positions of system_control_reg
    localparam int POS_STANDBY_SEL = 7;
    localparam int POS_STS_HI = 6;
    localparam int POS_STS_LO = 4;
    localparam int POS_NMI_EDGE = 2;

    // Reset values of the control fields
    localparam logic RST_STANDBY_SEL = 1'h0;
    localparam logic [2:0] RST_STS = 3'h0;
    localparam logic RST_NMI_EDGE = 1'h0;
    // NMI history starts at the pin's idle high level
    localparam logic RST_NMI_PREV = 1'h1;

    // Field positions of the status register
    localparam int POS_STATE_LO = 0;
    localparam int POS_IMASK = 6;

    // Settle-time codes and their lengths in system clock states
    localparam logic [2:0] STS_8K = 3'h0;
    localparam logic [2:0] STS_16K = 3'h1;
    localparam logic [2:0] STS_32K = 3'h2;
    localparam logic [2:0] STS_64K = 3'h3;
    localparam logic [2:0] STS_128K = 3'h4;
    localparam logic [2:0] STS_1K = 3'h5;
    localparam int SETTLE_STATES_0 = 8192;
    localparam int SETTLE_STATES_1 = 16384;
    localparam int SETTLE_STATES_2 = 32768;
    localparam int SETTLE_STATES_3 = 65536;
    localparam int SETTLE_STATES_4 = 131072;
    localparam int SETTLE_STATES_5 = 1024;
    localparam int SETTLE_CNT_W = 18;

    // External interrupt lines that may wake from software standby
    localparam int NUM_IRQ = 8;
    localparam logic [7:0] STANDBY_WAKE_IRQ = 8'h47;

    // Power state, one-hot
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_SLEEP = 6'h02,
        ST_SWSTANDBY = 6'h04,
        ST_SETTLE = 6'h08,
        ST_RESET = 6'h10,
        ST_HWSTBY = 6'h20
    } pdc_state_t;

endpackage : pdc_pkg

// File: rtl/pdc_settle_cnt.sv
// Oscillator settling counter for wake-up from software standby
`timescale 1ns/1ps
module pdc_settle_cnt #(
    parameter int CNT_W = pdc_pkg::SETTLE_CNT_W
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic [CNT_W-1:0] i_len,
    // Status
    output logic o_busy,
    output logic o_done
);

    typedef struct packed {
        logic busy;
        logic [CNT_W-1:0] cnt;
    } pdc_cnt_st_t;

    pdc_cnt_st_t st_q;
    pdc_cnt_st_t st_d;

    // Count down; done fires in the last state of the wait
    always_comb begin
        st_d = st_q;
        if (i_abort) begin
            st_d.busy = 1'b0;
        end else if (i_start) begin
            st_d.busy = 1'b1;
            st_d.cnt = i_len;
        end else if (st_q.busy) begin
            st_d.cnt = st_q.cnt - 1'b1;
            if (st_q.cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                st_d.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_busy = st_q.busy;
    // Combinational so the wake lands exactly on the selected count
    assign o_done = st_q.busy && !i_abort && (st_q.cnt == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule : pdc_settle_cnt

// File: rtl/pdc_ctrl.sv
// Power-down mode controller: sleep, software standby and settling wait
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module pdc_ctrl #(
    parameter int NUM_PIRQ = 8,
    parameter int P_SETTLE_0 = pdc_pkg::SETTLE_STATES_0,
    parameter int P_SETTLE_1 = pdc_pkg::SETTLE_STATES_1,
    parameter int P_SETTLE_2 = pdc_pkg::SETTLE_STATES_2,
    parameter int P_SETTLE_3 = pdc_pkg::SETTLE_STATES_3,
    parameter int P_SETTLE_4 = pdc_pkg::SETTLE_STATES_4,
    parameter int P_SETTLE_5 = pdc_pkg::SETTLE_STATES_5
) (
    // Clock and power-on reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Register port
    input wire logic [pdc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pdc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [pdc_pkg::DATA_W-1:0] o_rdata,
    // CPU side
    input wire logic i_sleep_exec,
    input wire logic i_imask,
    // Interrupt sources
    input wire logic i_nmi,
    input wire logic [pdc_pkg::NUM_IRQ-1:0] i_irq_req,
    input wire logic [pdc_pkg::NUM_IRQ-1:0] i_irq_en,
    input wire logic [7:0] i_key_wake_input_n,
    input wire logic [NUM_PIRQ-1:0] i_periph_irq_req,
    input wire logic [NUM_PIRQ-1:0] i_periph_irq_en,
    // External control pins
    input wire logic i_external_reset_in_n,
    input wire logic i_hw_standby_in_n,
    // Power control outputs
    output logic o_cpu_halt,
    output logic o_clk_en,
    output logic o_osc_en,
    output logic o_periph_run,
    output logic o_periph_rst_n,
    output logic o_port_hold,
    output logic o_port_hiz,
    output logic o_chip_reset,
    output logic o_wake_irq,
    output logic o_reset_exc
);

    localparam int CW = pdc_pkg::SETTLE_CNT_W;

    // Refuse settle lengths the counter cannot hold
    initial begin
        if (P_SETTLE_0 < 2 || P_SETTLE_0 >= (1 << CW) || P_SETTLE_1 < 2 ||
            P_SETTLE_1 >= (1 << CW) || P_SETTLE_2 < 2 || P_SETTLE_2 >= (1 << CW) ||
            P_SETTLE_3 < 2 || P_SETTLE_3 >= (1 << CW) || P_SETTLE_4 < 2 ||
            P_SETTLE_4 >= (1 << CW) || P_SETTLE_5 < 2 || P_SETTLE_5 >= (1 << CW) ||
            NUM_PIRQ < 1) begin
            $error("pdc_ctrl: settle length or peripheral count out of range");
        end
    end

    typedef struct packed {
        pdc_pkg::pdc_state_t state;
        logic standby_sel;
        logic [2:0] sts;
        logic nmi_edge_sel;
        logic imask;
        logic nmi_prev;
        logic [pdc_pkg::DATA_W-1:0] rdata;
        logic wake_irq;
        logic reset_exc;
        logic [CW-1:0] wait_cnt;
    } pdc_ctrl_st_t;

    pdc_ctrl_st_t st_q;
    pdc_ctrl_st_t st_d;

    logic nmi_edge;
    logic sleep_wake;
    logic swstandby_wake;
    logic [pdc_pkg::NUM_IRQ-1:0] irq_live;
    logic cnt_start;
    logic cnt_abort;
    logic cnt_done;
    logic [CW-1:0] settle_len;

    // Wait length per code; unused codes take the code 4 wait, the longest at default lengths
    always_comb begin
        if (st_q.sts == pdc_pkg::STS_8K) begin
            settle_len = CW'(P_SETTLE_0);
        end else if (st_q.sts == pdc_pkg::STS_16K) begin
            settle_len = CW'(P_SETTLE_1);
        end else if (st_q.sts == pdc_pkg::STS_32K) begin
            settle_len = CW'(P_SETTLE_2);
        end else if (st_q.sts == pdc_pkg::STS_64K) begin
            settle_len = CW'(P_SETTLE_3);
        end else if (st_q.sts == pdc_pkg::STS_1K) begin
            settle_len = CW'(P_SETTLE_5);
        end else begin
            settle_len = CW'(P_SETTLE_4);
        end
    end

    // NMI edge picked by the edge select bit
    assign nmi_edge = st_q.nmi_edge_sel ? (i_nmi && !st_q.nmi_prev)
                                 : (!i_nmi && st_q.nmi_prev);

    // Key inputs join external interrupt 6; every request needs its enable
    always_comb begin
        irq_live = i_irq_req & i_irq_en;
        irq_live[6] = (i_irq_req[6] || !(&i_key_wake_input_n)) && i_irq_en[6];
    end

    // Sleep wakes on any request; masked entry leaves only NMI
    assign sleep_wake = nmi_edge || (!st_q.imask &&
        ((|irq_live) || (|(i_periph_irq_req & i_periph_irq_en))));

    // Only NMI and lines 0-2, 6 reach through standby; software owns the rest
    assign swstandby_wake = nmi_edge || (|(irq_live & pdc_pkg::STANDBY_WAKE_IRQ));

    // Next-state and register logic
    always_comb begin
        st_d = st_q;
        st_d.nmi_prev = i_nmi;
        st_d.wake_irq = 1'b0;
        st_d.reset_exc = 1'b0;
        st_d.rdata = '0;
        st_d.wait_cnt = (st_q.state == pdc_pkg::ST_SETTLE) ? st_q.wait_cnt + 1'b1 : '0;
        // Register writes; besides these, only the reset and hardware standby states clear the select bit
        if (i_wr && i_addr == pdc_pkg::OFS_SYSCTL) begin
            st_d.standby_sel = i_wdata[pdc_pkg::POS_STANDBY_SEL];
            st_d.sts = i_wdata[pdc_pkg::POS_STS_HI:pdc_pkg::POS_STS_LO];
            st_d.nmi_edge_sel = i_wdata[pdc_pkg::POS_NMI_EDGE];
        end
        // Register reads, data one cycle later
        if (i_rd && i_addr == pdc_pkg::OFS_SYSCTL) begin
            st_d.rdata[pdc_pkg::POS_STANDBY_SEL] = st_q.standby_sel;
            st_d.rdata[pdc_pkg::POS_STS_HI:pdc_pkg::POS_STS_LO] = st_q.sts;
            st_d.rdata[pdc_pkg::POS_NMI_EDGE] = st_q.nmi_edge_sel;
        end else if (i_rd && i_addr == pdc_pkg::OFS_STATUS) begin
            st_d.rdata[pdc_pkg::POS_STATE_LO +: 6] = st_q.state;
            st_d.rdata[pdc_pkg::POS_IMASK] = st_q.imask;
        end
        // Standby pin beats reset pin, which beats interrupts
        if (!i_hw_standby_in_n) begin
            st_d.state = pdc_pkg::ST_HWSTBY;
        end else if (!i_external_reset_in_n) begin
            st_d.state = pdc_pkg::ST_RESET;
        end else begin
            case (st_q.state)
                pdc_pkg::ST_RUN: begin
                    if (i_sleep_exec) begin
                        st_d.imask = i_imask;
                        st_d.state = st_q.standby_sel ? pdc_pkg::ST_SWSTANDBY
                                               : pdc_pkg::ST_SLEEP;
                    end
                end
                pdc_pkg::ST_SLEEP: begin
                    if (sleep_wake) begin
                        st_d.state = pdc_pkg::ST_RUN;
                        st_d.wake_irq = 1'b1;
                    end
                end
                pdc_pkg::ST_SWSTANDBY: begin
                    if (swstandby_wake) begin
                        st_d.state = pdc_pkg::ST_SETTLE;
                    end
                end
                pdc_pkg::ST_SETTLE: begin
                    if (cnt_done) begin
                        st_d.state = pdc_pkg::ST_RUN;
                        st_d.wake_irq = 1'b1;
                    end
                end
                pdc_pkg::ST_RESET: begin
                    st_d.state = pdc_pkg::ST_RUN;
                    st_d.reset_exc = 1'b1;
                end
                pdc_pkg::ST_HWSTBY: begin
                    // Leaving needs the reset pin low, caught above
                    st_d.state = pdc_pkg::ST_HWSTBY;
                end
                default: begin
                    st_d.state = pdc_pkg::ST_RUN;
                end
            endcase
        end
        // Reset state and hardware standby put the control fields back
        if (st_q.state == pdc_pkg::ST_RESET || st_q.state == pdc_pkg::ST_HWSTBY) begin
            st_d.standby_sel = pdc_pkg::RST_STANDBY_SEL;
            st_d.sts = pdc_pkg::RST_STS;
            st_d.nmi_edge_sel = pdc_pkg::RST_NMI_EDGE;
        end
    end

    // State register; NMI history starts high so no false edge follows reset
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= '{state: pdc_pkg::ST_RUN, standby_sel: pdc_pkg::RST_STANDBY_SEL,
                      sts: pdc_pkg::RST_STS, nmi_edge_sel: pdc_pkg::RST_NMI_EDGE,
                      nmi_prev: pdc_pkg::RST_NMI_PREV, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // Counter loads on entry to the wait and drops on any pin exit
    assign cnt_start = (st_d.state == pdc_pkg::ST_SETTLE) &&
                       (st_q.state != pdc_pkg::ST_SETTLE);
    assign cnt_abort = (st_q.state == pdc_pkg::ST_SETTLE) &&
                       (!i_hw_standby_in_n || !i_external_reset_in_n);

    // Settling counter; the master clock stands in for the oscillator output
    pdc_settle_cnt #(
        .CNT_W(CW)
    ) u_settle (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_start(cnt_start),
        .i_abort(cnt_abort),
        .i_len(settle_len),
        .o_busy(),
        .o_done(cnt_done)
    );

    // Power control decode from the one-hot state
    assign o_cpu_halt = (st_q.state != pdc_pkg::ST_RUN);
    assign o_clk_en = (st_q.state == pdc_pkg::ST_RUN) ||
                      (st_q.state == pdc_pkg::ST_SLEEP) ||
                      (st_q.state == pdc_pkg::ST_RESET);
    assign o_osc_en = (st_q.state != pdc_pkg::ST_SWSTANDBY) &&
                      (st_q.state != pdc_pkg::ST_HWSTBY);
    assign o_periph_run = (st_q.state == pdc_pkg::ST_RUN) ||
                          (st_q.state == pdc_pkg::ST_SLEEP);
    // Peripherals held in reset for the whole standby span
    assign o_periph_rst_n = (st_q.state == pdc_pkg::ST_RUN) ||
                            (st_q.state == pdc_pkg::ST_SLEEP);
    // Hold keeps output current flowing; that is the price of retention
    assign o_port_hold = (st_q.state == pdc_pkg::ST_SLEEP) ||
                         (st_q.state == pdc_pkg::ST_SWSTANDBY) ||
                         (st_q.state == pdc_pkg::ST_SETTLE);
    assign o_port_hiz = (st_q.state == pdc_pkg::ST_HWSTBY);
    assign o_chip_reset = (st_q.state == pdc_pkg::ST_RESET);
    assign o_wake_irq = st_q.wake_irq;
    assign o_reset_exc = st_q.reset_exc;
    assign o_rdata = st_q.rdata;

    // Pins released for checks below
    logic pins_idle;
    assign pins_idle = i_hw_standby_in_n && i_external_reset_in_n;

    sequence enter_settle_s;
        st_q.state == pdc_pkg::ST_SWSTANDBY && swstandby_wake && pins_idle;
    endsequence

    sequence leave_settle_s;
        st_q.state == pdc_pkg::ST_SETTLE && st_d.state == pdc_pkg::ST_RUN;
    endsequence

    sleep_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        st_q.state == pdc_pkg::ST_RUN && i_sleep_exec && !st_q.standby_sel && pins_idle
        |=> st_q.state == pdc_pkg::ST_SLEEP && o_periph_run && o_cpu_halt)
        else $error("sleep entry missed");

    standby_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        st_q.state == pdc_pkg::ST_RUN && i_sleep_exec && st_q.standby_sel && pins_idle
        |=> st_q.state == pdc_pkg::ST_SWSTANDBY && !o_clk_en && !o_periph_rst_n)
        else $error("software standby entry missed");

    masked_sleep_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        st_q.state == pdc_pkg::ST_SLEEP && st_q.imask && !nmi_edge && pins_idle
        |=> st_q.state == pdc_pkg::ST_SLEEP && !o_wake_irq)
        else $error("masked sleep woke without NMI");

    sleep_wake_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        st_q.state == pdc_pkg::ST_SLEEP && nmi_edge && pins_idle
        |=> o_wake_irq && st_q.state == pdc_pkg::ST_RUN ##1 !o_wake_irq)
        else $error("sleep wake pulse wrong");

    settle_start_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        enter_settle_s |=> st_q.state == pdc_pkg::ST_SETTLE && o_osc_en && !o_clk_en)
        else $error("settle wait not started");

    settle_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        leave_settle_s |-> st_q.wait_cnt == settle_len - 1'b1)
        else $error("settle wait length wrong");

    settle_wake_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        leave_settle_s |=> o_wake_irq && !o_cpu_halt && o_periph_rst_n)
        else $error("no interrupt after settle");

    reset_pin_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_hw_standby_in_n && !i_external_reset_in_n
        |=> o_chip_reset && o_osc_en ##1 (o_chip_reset or o_reset_exc))
        else $error("reset pin not obeyed");

    hw_standby_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !i_hw_standby_in_n |=> o_port_hiz && !o_osc_en && !o_clk_en)
        else $error("hardware standby not entered");

    select_keep_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        leave_settle_s and !i_wr |=> st_q.standby_sel)
        else $error("select bit lost on wake");

endmodule : pdc_ctrl

// File: test/pdc_cpu_model.sv
// Behavioural CPU, interrupt and pin side facing the power-down controller
`timescale 1ns/1ps
module pdc_cpu_model (
    // Clock
    input wire logic i_mclk,
    // CPU side
    output logic o_sleep_exec,
    output logic o_imask,
    // Interrupt sources
    output logic o_nmi,
    output logic [7:0] o_irq_req,
    output logic [7:0] o_irq_en,
    output logic [7:0] o_key_n,
    output logic [7:0] o_pirq_req,
    output logic [7:0] o_pirq_en,
    // External pins
    output logic o_ext_reset_n,
    output logic o_hw_standby_n
);
    // Idle: no request pending, NMI high, both pins released
    initial begin
        o_sleep_exec = 1'b0;
        o_imask = 1'b0;
        o_nmi = 1'b1;
        o_irq_req = 8'h00;
        o_irq_en = 8'h00;
        o_key_n = 8'hFF;
        o_pirq_req = 8'h00;
        o_pirq_en = 8'h00;
        o_ext_reset_n = 1'b1;
        o_hw_standby_n = 1'b1;
    end

    // Halt entry; for standby, lines that cannot wake it are shut off first
    task automatic halt(input logic mask, input logic sby);
        @(posedge i_mclk);
        if (sby) o_irq_en <= o_irq_en & 8'h47;
        @(posedge i_mclk);
        o_sleep_exec <= 1'b1;
        o_imask <= mask;
        @(posedge i_mclk);
        o_sleep_exec <= 1'b0;
    endtask : halt

    // Source select: 0 NMI level, 1..8 line 0..7, 9 key 0, 10 peripheral 0
    task automatic set_src(input int idx, input logic act);
        @(posedge i_mclk);
        case (idx)
            0: o_nmi <= act;
            9: o_key_n[0] <= ~act;
            10: o_pirq_req[0] <= act;
            default: o_irq_req[idx-1] <= act;
        endcase
    endtask : set_src

    // Enables of external lines and peripheral modules
    task automatic set_en(input logic [7:0] en, input logic [7:0] pen);
        @(posedge i_mclk);
        o_irq_en <= en;
        o_pirq_en <= pen;
    endtask : set_en

    // Reset and standby pin levels
    task automatic pins(input logic rst_lvl_n, input logic sby_lvl_n);
        @(posedge i_mclk);
        o_ext_reset_n <= rst_lvl_n;
        o_hw_standby_n <= sby_lvl_n;
    endtask : pins
endmodule : pdc_cpu_model

// File: test/tb_top.sv
// Self-checking bench for the power-down mode controller
`timescale 1ns/1ps
module tb_top;
    logic i_mclk;
    logic i_rst_b;
    logic [1:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    logic s_exec, s_mask, s_nmi, s_ext_reset_n, s_hw_standby_n;
    logic [7:0] s_irq, s_en, s_key_n, s_preq, s_pen;
    logic o_cpu_halt, o_clk_en, o_osc_en, o_periph_run, o_periph_rst_n;
    logic o_port_hold, o_port_hiz, o_chip_reset, o_wake_irq, o_reset_exc;
    logic [7:0] pwr;
    logic [7:0] p1;
    logic [7:0] ctl;
    int n_errors = 0;
    int check_count = 0;
    // Small settle lengths keep the run short; code 5 keeps its full length
    // The bench clock acts as an external clock, so the crystal minimum does not bind
    int lens[7] = '{4, 5, 6, 7, 8, pdc_pkg::SETTLE_STATES_5, 8};
    int srcs[7] = '{0, 1, 2, 3, 7, 9, 7};

    // Power outputs packed as one byte for compact comparison
    assign pwr = {o_cpu_halt, o_clk_en, o_osc_en, o_periph_run,
                  o_periph_rst_n, o_port_hold, o_port_hiz, o_chip_reset};

    pdc_ctrl #(.P_SETTLE_0(4), .P_SETTLE_1(5), .P_SETTLE_2(6),
               .P_SETTLE_3(7), .P_SETTLE_4(8)) DUT (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep_exec(s_exec),
        .i_imask(s_mask), .i_nmi(s_nmi), .i_irq_req(s_irq), .i_irq_en(s_en),
        .i_key_wake_input_n(s_key_n), .i_periph_irq_req(s_preq),
        .i_periph_irq_en(s_pen), .i_external_reset_in_n(s_ext_reset_n),
        .i_hw_standby_in_n(s_hw_standby_n), .o_cpu_halt(o_cpu_halt), .o_clk_en(o_clk_en),
        .o_osc_en(o_osc_en), .o_periph_run(o_periph_run),
        .o_periph_rst_n(o_periph_rst_n), .o_port_hold(o_port_hold),
        .o_port_hiz(o_port_hiz), .o_chip_reset(o_chip_reset),
        .o_wake_irq(o_wake_irq), .o_reset_exc(o_reset_exc));

    pdc_cpu_model u_cpu (
        .i_mclk(i_mclk), .o_sleep_exec(s_exec), .o_imask(s_mask), .o_nmi(s_nmi),
        .o_irq_req(s_irq), .o_irq_en(s_en), .o_key_n(s_key_n), .o_pirq_req(s_preq),
        .o_pirq_en(s_pen), .o_ext_reset_n(s_ext_reset_n), .o_hw_standby_n(s_hw_standby_n));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data looked at in the following cycle only
    task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata & m, exp);
    endtask : rd

    // State code from status plus the power output pattern
    task automatic st(input logic [7:0] s, input logic [7:0] p);
        rd(2'h1, 8'h3F, s);
        chk(pwr, p);
    endtask : st

    // Edges from the sampling edge until the pulse, bounded
    task automatic wait_ev(input logic sel, input int n);
        int k;
        for (k = 1; k <= 1100; k++) begin
            @(posedge i_mclk);
            #1;
            if (k == 1) p1 = pwr;
            if ((sel ? o_reset_exc : o_wake_irq) === 1'b1) break;
        end
        if (k > 1100) begin
            n_errors++;
            wrap_up();
        end else begin
            chk(k[15:8], n[15:8]);
            chk(k[7:0], n[7:0]);
        end
    endtask : wait_ev

    // Leave hardware standby: reset low first, standby high, then reset high
    task automatic hw_exit;
        u_cpu.pins(1'b0, 1'b0);
        u_cpu.pins(1'b0, 1'b1);
        st(8'h10, 8'hE1);
        u_cpu.pins(1'b1, 1'b1);
        wait_ev(1'b1, 1);
    endtask : hw_exit

    task automatic endt(input string name);
        $display("test %s done", name);
    endtask : endt

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // 40 MHz system clock
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    // Main sequence
    initial begin
        i_rst_b = 1'b0;
        i_addr = 2'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        rd(2'h0, 8'hFF, 8'h00);
        st(8'h01, 8'h78);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'hFF, 8'h00);
        rd(2'h2, 8'hFF, 8'h00);
        endt("reset");
        // Disabled peripheral request must not wake; enabling it does
        u_cpu.halt(1'b0, 1'b0);
        st(8'h02, 8'hFC);
        u_cpu.set_src(10, 1'b1);
        repeat (4) @(posedge i_mclk);
        st(8'h02, 8'hFC);
        u_cpu.set_en(8'h00, 8'h01);
        wait_ev(1'b0, 1);
        chk(p1, 8'h78);
        endt("sleep");
        // Mask set at entry: only a falling NMI edge wakes
        u_cpu.set_en(8'h08, 8'h01);
        u_cpu.set_src(4, 1'b1);
        u_cpu.halt(1'b1, 1'b0);
        rd(2'h1, 8'hFF, 8'h42);
        repeat (4) @(posedge i_mclk);
        st(8'h02, 8'hFC);
        u_cpu.set_src(0, 1'b0);
        wait_ev(1'b0, 1);
        u_cpu.set_src(4, 1'b0);
        u_cpu.set_src(10, 1'b0);
        u_cpu.set_src(0, 1'b1);
        endt("mask");
        // Reset pin in sleep; control fields cleared meanwhile
        wr(2'h0, 8'h34);
        u_cpu.halt(1'b0, 1'b0);
        u_cpu.pins(1'b0, 1'b1);
        st(8'h10, 8'hE1);
        rd(2'h0, 8'hFF, 8'h00);
        u_cpu.pins(1'b1, 1'b1);
        wait_ev(1'b1, 1);
        st(8'h01, 8'h78);
        u_cpu.halt(1'b0, 1'b0);
        u_cpu.pins(1'b1, 1'b0);
        st(8'h20, 8'h82);
        hw_exit();
        endt("sleep pins");
        // Settle codes 0 to 6, each with a wake source; codes 4 and 6 both use line 6
        for (int c = 0; c < 7; c++) begin
            ctl = 8'h80 | (c[7:0] << 4) | ((c == 0) ? 8'h04 : 8'h00);
            wr(2'h0, ctl);
            if (c == 0) u_cpu.set_src(0, 1'b0);
            u_cpu.set_en(8'hFF, 8'h00);
            u_cpu.halt(1'b0, 1'b1);
            st(8'h04, 8'h84);
            u_cpu.set_src(srcs[c], 1'b1);
            wait_ev(1'b0, lens[c] + 1);
            chk(p1, 8'hA4);
            rd(2'h0, 8'hFF, ctl);
            if (c == 5) wr(2'h0, 8'hC0);
            u_cpu.set_src(srcs[c], c == 0);
        end
        endt("standby wake");
        // Pins during software standby
        wr(2'h0, 8'h80);
        u_cpu.halt(1'b0, 1'b1);
        u_cpu.pins(1'b0, 1'b1);
        st(8'h10, 8'hE1);
        u_cpu.pins(1'b1, 1'b1);
        wait_ev(1'b1, 1);
        wr(2'h0, 8'h80);
        u_cpu.halt(1'b0, 1'b1);
        u_cpu.pins(1'b1, 1'b0);
        st(8'h20, 8'h82);
        hw_exit();
        endt("standby pins");
        wrap_up();
    end
endmodule : tb_top
